/* logic/timer_gate_defines.vh */
`ifndef TIMER_GATE_DEFINES_VH
`define TIMER_GATE_DEFINES_VH

// register byte addresses
`define ADDR_GATE_CTRL 4'h0
`define ADDR_TIMER_CTRL 4'h4
`define ADDR_IRQ_STATUS 4'h8
`define ADDR_IRQ_MASK 4'hc

// gate control field positions
`define GC_ENABLE 7
`define GC_POLARITY 6
`define GC_TOGGLE 5
`define GC_SINGLE 4
`define GC_GO_DONE 3
`define GC_LIVE 2
`define GC_SRC_HI 1
`define GC_SRC_LO 0

// timer control field positions
`define TC_RUN 0

// interrupt status / mask field positions
`define IRQ_DONE 0
`define IRQ_EDGE 1
`define IRQ_WIDTH 2

// gate source codes
`define SRC_PIN 2'h0
`define SRC_OVERFLOW 2'h1
`define SRC_PERIOD 2'h2
`define SRC_WATCHDOG 2'h3

// reset values
`define GATE_CTRL_RESET 8'h00
`define TIMER_CTRL_RESET 1'h0
`define IRQ_RESET 2'h0

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// single-pulse acquisition states
`define PULSE_IDLE 2'h0
`define PULSE_ARMED 2'h1
`define PULSE_OPEN 2'h2

`endif

/* logic/timer_gate_control.v */
`include "timer_gate_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_gate_control (
    input wire clock,
    input wire sys_rst,
    input wire clockEnable,
    // gate sources
    input wire gatePin,
    input wire overflowOut,
    input wire periodMatchOut,
    input wire watchdogScalerOut,
    // qualified counting
    input wire countTick,
    output reg countAdvance,
    output reg irq,
    // AXI4-Lite slave
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);

    // control fields
    reg gateEnable;
    reg gatePolarity;
    reg toggleMode;
    reg singlePulseMode;
    reg goDone;
    reg [1:0] sourceSelect;
    reg timerRun;
    reg [`IRQ_WIDTH-1:0] irqStatus;
    reg [`IRQ_WIDTH-1:0] irqMask;

    // pin synchroniser
    reg pinSync1;
    reg pinSync2;
    reg pinSync3;
    reg pinLevel;

    // gate processing state
    reg polarPrev;
    reg toggleFlop;
    reg gatedPrev;
    reg [1:0] pulseState;
    reg gateLive;

    // bus state
    reg awHeld;
    reg wHeld;
    reg [3:0] writeAddr;
    reg [7:0] writeData;
    reg writeLane0;

    wire [1:0] irqEvents;
    reg selectedSource;
    reg next_gateLive;
    reg [1:0] next_pulseState;
    reg pulseDoneEvent;
    reg [31:0] readWord;
    reg readHit;
    wire writeFire;
    wire readFire;
    wire statusRead;
    wire polarSignal;
    wire toggledSignal;
    wire toggledRise;

    // pin: three stages, level taken only once stages two and three agree
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pinSync1 <= 1'b0;
            pinSync2 <= 1'b0;
            pinSync3 <= 1'b0;
            pinLevel <= 1'b0;
        end else if (clockEnable) begin
            pinSync1 <= gatePin;
            pinSync2 <= pinSync1;
            pinSync3 <= pinSync2;
            if (pinSync2 == pinSync3) begin
                pinLevel <= pinSync3;
            end
        end
    end

    always @* begin
        case (sourceSelect)
            `SRC_PIN: selectedSource = pinLevel;
            `SRC_OVERFLOW: selectedSource = overflowOut;
            `SRC_PERIOD: selectedSource = periodMatchOut;
            `SRC_WATCHDOG: selectedSource = watchdogScalerOut;
            default: selectedSource = pinLevel;
        endcase
    end

    // after polarity the gate is active high everywhere downstream
    assign polarSignal = gatePolarity ? selectedSource : ~selectedSource;
    assign toggledSignal = toggleMode ? toggleFlop : polarSignal;
    assign toggledRise = toggledSignal & ~gatedPrev;

    // single-pulse acquisition: armed waits for a rising edge, open lasts to the falling edge
    always @* begin
        next_pulseState = pulseState;
        pulseDoneEvent = 1'b0;
        next_gateLive = toggledSignal;
        if (!singlePulseMode) begin
            next_pulseState = `PULSE_IDLE;
        end else begin
            case (pulseState)
                `PULSE_IDLE: begin
                    next_gateLive = 1'b0;
                    if (goDone) begin
                        next_pulseState = `PULSE_ARMED;
                    end
                end
                `PULSE_ARMED: begin
                    next_gateLive = 1'b0;
                    // go written 0 cancels a waiting acquisition
                    if (!goDone) begin
                        next_pulseState = `PULSE_IDLE;
                    end else if (toggledRise) begin
                        next_pulseState = `PULSE_OPEN;
                        next_gateLive = 1'b1;
                    end
                end
                `PULSE_OPEN: begin
                    if (!toggledSignal) begin
                        next_pulseState = `PULSE_IDLE;
                        pulseDoneEvent = 1'b1;
                    end
                end
                default: begin
                    next_pulseState = `PULSE_IDLE;
                    next_gateLive = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            // after reset the gate idles active (low pin, active-low polarity): no false rising edge
            polarPrev <= 1'b1;
            toggleFlop <= 1'b0;
            gatedPrev <= 1'b1;
            pulseState <= `PULSE_IDLE;
            gateLive <= 1'b0;
        end else if (clockEnable) begin
            polarPrev <= polarSignal;
            if (!toggleMode || !timerRun) begin
                toggleFlop <= 1'b0;
            end else if (polarSignal && !polarPrev) begin
                toggleFlop <= ~toggleFlop;
            end
            gatedPrev <= toggledSignal;
            pulseState <= next_pulseState;
            gateLive <= next_gateLive;
        end
    end

    // count enable moves with the live gate in the same cycle, registered from its next value
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            countAdvance <= 1'b0;
        end else if (clockEnable) begin
            if (!timerRun) begin
                countAdvance <= 1'b0;
            end else if (!gateEnable) begin
                countAdvance <= countTick;
            end else begin
                countAdvance <= countTick & next_gateLive;
            end
        end
    end

    assign writeFire = awHeld && wHeld && !s_axi_bvalid;
    assign readFire = s_axi_arvalid && s_axi_arready;
    assign statusRead = readFire && (s_axi_araddr == `ADDR_IRQ_STATUS);
    assign irqEvents = {toggledRise, pulseDoneEvent};

    // write channel: address and data taken in either order
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            writeAddr <= 4'h0;
            writeData <= 8'h00;
            writeLane0 <= 1'b0;
        end else if (clockEnable) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            if (s_axi_awvalid && !awHeld && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
            end
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld <= 1'b1;
                writeAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !wHeld && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld <= 1'b1;
                writeData <= s_axi_wdata[7:0];
                writeLane0 <= s_axi_wstrb[0];
            end
            if (writeFire) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (writeAddr)
                    `ADDR_GATE_CTRL, `ADDR_TIMER_CTRL, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK:
                        s_axi_bresp <= `RESP_OKAY;
                    default:
                        s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            gateEnable <= 1'b0;
            gatePolarity <= 1'b0;
            toggleMode <= 1'b0;
            singlePulseMode <= 1'b0;
            goDone <= 1'b0;
            sourceSelect <= `SRC_PIN;
            timerRun <= `TIMER_CTRL_RESET;
            irqMask <= `IRQ_RESET;
        end else if (clockEnable) begin
            if (pulseDoneEvent) begin
                goDone <= 1'b0;
            end
            if (writeFire && writeLane0) begin
                case (writeAddr)
                    `ADDR_GATE_CTRL: begin
                        gateEnable <= writeData[`GC_ENABLE];
                        gatePolarity <= writeData[`GC_POLARITY];
                        toggleMode <= writeData[`GC_TOGGLE];
                        singlePulseMode <= writeData[`GC_SINGLE];
                        sourceSelect <= writeData[`GC_SRC_HI:`GC_SRC_LO];
                        // go only arms with single-pulse mode on; clearing the mode drops it
                        if (!writeData[`GC_SINGLE]) begin
                            goDone <= 1'b0;
                        end else if (writeData[`GC_GO_DONE] && pulseState == `PULSE_IDLE) begin
                            goDone <= 1'b1;
                        end else if (!writeData[`GC_GO_DONE]) begin
                            goDone <= 1'b0;
                        end
                    end
                    `ADDR_TIMER_CTRL: timerRun <= writeData[`TC_RUN];
                    `ADDR_IRQ_MASK: irqMask <= writeData[`IRQ_WIDTH-1:0];
                    default: ;
                endcase
            end
        end
    end

    // sticky status: an event in the cycle of a clearing read survives
    genvar i;
    generate
        for (i = 0; i < `IRQ_WIDTH; i = i + 1) begin : statusBits
            always @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    irqStatus[i] <= 1'b0;
                end else if (clockEnable) begin
                    if (irqEvents[i]) begin
                        irqStatus[i] <= 1'b1;
                    end else if (statusRead) begin
                        irqStatus[i] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
        end else if (clockEnable) begin
            irq <= |(irqStatus & irqMask);
        end
    end

    always @* begin
        readWord = 32'h00000000;
        readHit = 1'b1;
        case (s_axi_araddr)
            `ADDR_GATE_CTRL: begin
                readWord[`GC_ENABLE] = gateEnable;
                readWord[`GC_POLARITY] = gatePolarity;
                readWord[`GC_TOGGLE] = toggleMode;
                readWord[`GC_SINGLE] = singlePulseMode;
                readWord[`GC_GO_DONE] = goDone;
                readWord[`GC_LIVE] = gateLive;
                readWord[`GC_SRC_HI:`GC_SRC_LO] = sourceSelect;
            end
            `ADDR_TIMER_CTRL: readWord[`TC_RUN] = timerRun;
            `ADDR_IRQ_STATUS: readWord[`IRQ_WIDTH-1:0] = irqStatus;
            `ADDR_IRQ_MASK: readWord[`IRQ_WIDTH-1:0] = irqMask;
            default: readHit = 1'b0;
        endcase
    end

    // read channel
    always @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (clockEnable) begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
            end
            if (readFire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= readWord;
                s_axi_rresp <= readHit ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

/* dv/gate_source_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: gate sources and prescaler tick, changing just after an edge
module gate_source_model (
    input wire logic clock,
    input wire logic [3:0] level,
    input wire logic tickOn,
    output logic gatePin,
    output logic overflowOut,
    output logic periodMatchOut,
    output logic watchdogScalerOut,
    output logic countTick
);
    logic [4:0] held = 5'h00;

    always @(posedge clock) begin
        held <= {tickOn, level};
    end
    assign {countTick, watchdogScalerOut, periodMatchOut, overflowOut, gatePin} = held;
endmodule

`default_nettype wire

/* dv/timer_gate_control_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module timer_gate_control_monitor (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic countTick,
    input wire logic countAdvance,
    input wire logic irq,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence s_writeTaken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_readTaken;
        s_axi_arvalid && s_axi_arready;
    endsequence

    property p_writeResp;
        s_writeTaken |-> ##[1:2] s_axi_bvalid;
    endproperty
    property p_readResp;
        s_readTaken |=> s_axi_rvalid;
    endproperty
    property p_bHold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rHold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    property p_rUpper;
        s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    property p_readyPulse;
        s_axi_arready |=> !s_axi_arready;
    endproperty
    property p_advNeedsTick;
        countAdvance |-> $past(countTick);
    endproperty
    property p_resetQuiet;
        $fell(sys_rst) |-> !countAdvance && !irq && !s_axi_bvalid && !s_axi_rvalid;
    endproperty

    a_writeResp: assert property (p_writeResp) else $error("write response missing");
    a_readResp: assert property (p_readResp) else $error("read response missing");
    a_bHold: assert property (p_bHold) else $error("write response dropped early");
    a_rHold: assert property (p_rHold) else $error("read response dropped early");
    a_rUpper: assert property (p_rUpper) else $error("read data upper bits set");
    a_readyPulse: assert property (p_readyPulse) else $error("address ready longer than one cycle");
    a_advNeedsTick: assert property (p_advNeedsTick) else $error("advance without tick");
    a_resetQuiet: assert property (p_resetQuiet) else $error("outputs not quiet after reset");
endmodule

bind timer_gate_control timer_gate_control_monitor i_timer_gate_control_monitor (
    .clock, .sys_rst, .countTick, .countAdvance, .irq, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);

`default_nettype wire

/* dv/timer_gate_control_tb.sv */
`include "timer_gate_defines.vh"
`timescale 1ns/1ps
`default_nettype none

module timer_gate_control_tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic clockEnable = 1'b1;
    logic tickOn = 1'b1;
    logic [3:0] lvl = 4'h0;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic [3:0] s_axi_araddr = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic gatePin, overflowOut, periodMatchOut, watchdogScalerOut, countTick, countAdvance, irq;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [1:0] writeResp;
    int errors = 0;
    int checkCount = 0;

    gate_source_model i_gate_source_model (.clock, .level(lvl), .tickOn, .gatePin, .overflowOut,
        .periodMatchOut, .watchdogScalerOut, .countTick);
    timer_gate_control i_timer_gate_control (.clock, .sys_rst, .clockEnable, .gatePin, .overflowOut,
        .periodMatchOut, .watchdogScalerOut, .countTick, .countAdvance, .irq, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready);

    always #50 clock = ~clock;

    task automatic finish_test();
        $display("checks %0d errors %0d", checkCount, errors);
        if (errors == 0 && checkCount > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bound(input int n);
        if (n >= 40) begin
            errors++;
            finish_test();
        end
    endtask

    // outputs are read right after the edge, so they still hold their pre-edge value
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        int n;
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 40 && !(ad && wd); n++) begin
            @(posedge clock);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        bound(n);
        for (n = 0; n < 40 && !s_axi_bvalid; n++) @(posedge clock);
        bound(n);
        s_axi_bready <= 1'b1;
        @(posedge clock);
        writeResp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 40 && !(s_axi_arvalid && s_axi_arready); n++) @(posedge clock);
        bound(n);
        s_axi_arvalid <= 1'b0;
        for (n = 0; n < 40 && !s_axi_rvalid; n++) @(posedge clock);
        bound(n);
        // late ready keeps the response waiting one cycle
        s_axi_rready <= 1'b1;
        @(posedge clock);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d & m, exp);
        chk(r, `RESP_OKAY);
    endtask

    // gate pin goes through a synchroniser, so allow a few cycles
    task automatic settle();
        repeat (8) @(posedge clock);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        int i;
        // low pin with active-low polarity reads as an active gate
        for (i = 0; i < 4; i++) rdchk({i[1:0], 2'b00}, (i == 0) ? 32'h4 : 32'h0, 32'hffffffff);
        wr(4'h0, 8'h67);
        rdchk(4'h0, 32'h63, 32'hffffffff);
        wr(4'h0, 8'h97);
        rdchk(4'h0, 32'h93, 32'hffffffff);
        wr(4'hc, 8'h03);
        chk(writeResp, `RESP_OKAY);
        // lane 0 off and an unmapped address must both leave the mask alone
        s_axi_wstrb <= 4'he;
        wr(4'hc, 8'h00);
        s_axi_wstrb <= 4'hf;
        wr(4'h2, 8'hff);
        chk(writeResp, `RESP_SLVERR);
        rdchk(4'hc, 32'h3, 32'hffffffff);
        rd(4'h2, d, r);
        chk(r, `RESP_SLVERR);
        chk(d, 32'h0);
        $display("t_regs done");
    endtask

    task automatic t_gate();
        int i;
        logic en, pol, lv;
        wr(4'h4, 8'h01);
        for (i = 0; i < 8; i++) begin
            {en, pol, lv} = i[2:0];
            lvl <= {2'b00, lv, 1'b0};
            wr(4'h0, {en, pol, 6'h01});
            settle();
            chk(countAdvance, en ? lv == pol : 1'b1);
            rdchk(4'h0, {29'h0, lv == pol, 2'h0}, 32'h4);
        end
        tickOn <= 1'b0;
        settle();
        chk(countAdvance, 1'b0);
        tickOn <= 1'b1;
        wr(4'h4, 8'h00);
        settle();
        chk(countAdvance, 1'b0);
        wr(4'h4, 8'h01);
        for (i = 0; i < 4; i++) begin
            lvl <= 4'hf ^ (4'h1 << i);
            wr(4'h0, {6'h30, i[1:0]});
            settle();
            chk(countAdvance, 1'b0);
            lvl <= 4'h1 << i;
            settle();
            chk(countAdvance, 1'b1);
        end
        // clock enable low freezes the registered advance
        clockEnable <= 1'b0;
        lvl <= 4'h0;
        settle();
        chk(countAdvance, 1'b1);
        clockEnable <= 1'b1;
        settle();
        chk(countAdvance, 1'b0);
        $display("t_gate done");
    endtask

    task automatic t_toggle();
        int i;
        lvl <= 4'h0;
        wr(4'h0, 8'he1);
        settle();
        chk(countAdvance, 1'b0);
        for (i = 0; i < 3; i++) begin
            lvl <= 4'h2;
            settle();
            lvl <= 4'h0;
            settle();
            chk(countAdvance, i != 1);
        end
        wr(4'h0, 8'hc1);
        wr(4'h0, 8'he1);
        settle();
        chk(countAdvance, 1'b0);
        $display("t_toggle done");
    endtask

    task automatic t_pulse();
        wr(4'hc, 8'h01);
        rdchk(4'h8, 32'h0, 32'h1);
        wr(4'h0, 8'hd9);
        rdchk(4'h0, 32'h8, 32'h8);
        chk(countAdvance, 1'b0);
        lvl <= 4'h2;
        settle();
        chk(countAdvance, 1'b1);
        lvl <= 4'h0;
        settle();
        chk(countAdvance, 1'b0);
        chk(irq, 1'b1);
        rdchk(4'h0, 32'h0, 32'h8);
        rdchk(4'h8, 32'h1, 32'h1);
        settle();
        chk(irq, 1'b0);
        lvl <= 4'h2;
        settle();
        chk(countAdvance, 1'b0);
        lvl <= 4'h0;
        wr(4'hc, 8'h00);
        wr(4'h0, 8'hd9);
        lvl <= 4'h2;
        settle();
        lvl <= 4'h0;
        settle();
        chk(irq, 1'b0);
        rdchk(4'h8, 32'h1, 32'h1);
        wr(4'h0, 8'hd9);
        rdchk(4'h0, 32'h8, 32'h8);
        wr(4'h0, 8'hc9);
        rdchk(4'h0, 32'h0, 32'h8);
        $display("t_pulse done");
    endtask

    initial begin
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        t_regs();
        t_gate();
        t_toggle();
        t_pulse();
        finish_test();
    end
endmodule

`default_nettype wire
